//--- dv/testbench.sv
// self-checking bench for the periodic modulo counter
`timescale 1ns/1ps
module testbench;
   import pmc_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic extOscClk = 1'b0;
   logic lowPowerOscClk = 1'b0;
   logic toggleOut;
   logic irq;
   logic errSeen;
   logic [DATA_W-1:0] r;
   logic [15:0] c;
   logic t0;
   int miscompares = 0;
   int n_compared = 0;

   periodic_modulo_counter dut (.clk_sys(clk_sys), .nrst(nrst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extOscClk(extOscClk),
      .lowPowerOscClk(lowPowerOscClk), .toggleOut(toggleOut), .irq(irq));

   always #5 clk_sys = ~clk_sys;

   task automatic print_verdict();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // request held until pready is seen at a rising edge
   task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      r = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdcnt();
      apb(1'b0, ADDR_COUNT_LOW, 0);
      c[7:0] = r[7:0];
      apb(1'b0, ADDR_COUNT_HIGH, 0);
      c[15:8] = r[7:0];
   endtask

   task automatic cmp(logic [15:0] v);
      apb(1'b1, ADDR_COMPARE_HIGH, {24'h0, v[15:8]});
      apb(1'b1, ADDR_COMPARE_LOW, {24'h0, v[7:0]});
   endtask

   // source edges spaced well beyond the synchroniser delay
   task automatic pulse(logic lp, int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         if (lp)
            lowPowerOscClk <= 1'b1;
         else
            extOscClk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         if (lp)
            lowPowerOscClk <= 1'b0;
         else
            extOscClk <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask

   task automatic flag(logic e);
      apb(1'b0, ADDR_STATUS_CONTROL, 0);
      chk("period flag", e, r[FLAG_BIT]);
   endtask

   task automatic t_reset();
      apb(1'b0, ADDR_CLOCK_CONTROL, 0);
      chk("clock control", 0, r);
      apb(1'b0, ADDR_COMPARE_LOW, 0);
      chk("compare low", 0, r);
      rdcnt();
      chk("count", 0, c);
      apb(1'b0, 16'h0000, 0);
      chk("unmapped err", 1, errSeen);
   endtask

   task automatic t_wrap();
      cmp(16'h0005);
      apb(1'b1, ADDR_STATUS_CONTROL, 32'h50);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h01);
      pulse(0, 5);
      rdcnt();
      chk("count at compare", 5, c);
      flag(0);
      chk("pin before wrap", 0, toggleOut);
      pulse(0, 1);
      rdcnt();
      chk("count wrapped", 0, c);
      flag(1);
      chk("pin after wrap", 1, toggleOut);
      chk("irq", 1, irq);
   endtask

   task automatic t_flag_ro();
      apb(1'b1, ADDR_STATUS_CONTROL, 32'h50);
      flag(1);
      apb(1'b1, ADDR_STATUS_CONTROL, 32'hd0);
      flag(0);
      chk("irq cleared", 0, irq);
      apb(1'b1, ADDR_COUNT_LOW, 32'h33);
      apb(1'b1, ADDR_COUNT_HIGH, 32'h33);
      rdcnt();
      chk("count after write", 0, c);
   endtask

   // new compare must wait for the next wrap
   task automatic t_buffer();
      cmp(16'h0002);
      pulse(0, 3);
      rdcnt();
      chk("old compare kept", 3, c);
      pulse(0, 3);
      pulse(0, 3);
      rdcnt();
      chk("new compare used", 0, c);
   endtask

   task automatic t_irq_off();
      apb(1'b1, ADDR_STATUS_CONTROL, 32'h80);
      t0 = toggleOut;
      pulse(0, 3);
      flag(1);
      chk("irq disabled", 0, irq);
      chk("pin held", t0, toggleOut);
   endtask

   task automatic t_zero();
      cmp(16'h0000);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h01);
      repeat (2)
      begin
         apb(1'b1, ADDR_STATUS_CONTROL, 32'h80);
         pulse(0, 1);
         flag(1);
      end
      rdcnt();
      chk("count zero mod", 0, c);
   endtask

   task automatic t_restart();
      cmp(16'hffff);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h02);
      pulse(0, 4);
      rdcnt();
      chk("div2 count", 2, c);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h02);
      rdcnt();
      chk("same value kept", 2, c);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h01);
      rdcnt();
      chk("changed cleared", 0, c);
   endtask

   task automatic t_sources();
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h82);
      repeat (200) @(posedge clk_sys);
      rdcnt();
      chk("bus div2 range", 1, c >= 95 && c <= 110);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'hc1);
      repeat (300) @(posedge clk_sys);
      rdcnt();
      chk("bus div128 count", 2, c);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h46);
      pulse(0, 5);
      pulse(1, 99);
      rdcnt();
      chk("div100 early", 0, c);
      pulse(1, 1);
      rdcnt();
      chk("div100 step", 1, c);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h40);
      pulse(1, 5);
      rdcnt();
      chk("prescaler off", 0, c);
   endtask

   // stale events from earlier wraps are cleared before the live check
   task automatic t_events();
      apb(1'b1, ADDR_EVENT_MASK, 32'h1);
      apb(1'b0, ADDR_EVENT_STATUS, 0);
      chk("old wrap event", 1, r[EVT_WRAP]);
      apb(1'b0, ADDR_EVENT_MASK, 0);
      chk("event mask", 1, r);
      chk("irq idle", 0, irq);
      cmp(16'h0003);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h81);
      repeat (20) @(posedge clk_sys);
      chk("event irq", 1, irq);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h80);
      apb(1'b0, ADDR_EVENT_STATUS, 0);
      chk("wrap event", 1, r[EVT_WRAP]);
      chk("restart event", 1, r[EVT_RESTART]);
      apb(1'b0, ADDR_EVENT_STATUS, 0);
      chk("event cleared", 0, r[EVT_WRAP]);
      chk("irq low", 0, irq);
   endtask

   // reset while counting must bring clock control, compare low, count, period flag and pin back to their idle values
   task automatic t_midreset();
      apb(1'b1, ADDR_STATUS_CONTROL, 32'h50);
      apb(1'b1, ADDR_CLOCK_CONTROL, 32'h82);
      repeat (20) @(posedge clk_sys);
      flag(1);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      flag(0);
      chk("pin after reset", 0, toggleOut);
   endtask

   initial
   begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_wrap();
      t_flag_ro();
      t_buffer();
      t_irq_off();
      t_zero();
      t_restart();
      t_sources();
      t_events();
      t_midreset();
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end
endmodule

//--- rtl/clock_edge_sync.sv
// two-stage synchroniser with rising-edge pulse for a slow source clock
`timescale 1ns/1ps
module clock_edge_sync
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic srcLevel,
   output logic risePulse
);

   logic meta_q;
   logic meta_d;
   logic stable_q;
   logic stable_d;
   logic last_q;
   logic last_d;

   always_comb
   begin
      meta_d = srcLevel;
      stable_d = meta_q;
      last_d = stable_q;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         meta_q <= 1'b0;
         stable_q <= 1'b0;
         last_q <= 1'b0;
      end
      else
      begin
         meta_q <= meta_d;
         stable_q <= stable_d;
         last_q <= last_d;
      end
   end

   // only the second stage feeds the edge detector
   assign risePulse = stable_q & ~last_q;

endmodule

//--- rtl/periodic_modulo_counter.sv
// periodic modulo counter with prescaler, apb registers and toggle output
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module periodic_modulo_counter
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
   output logic [pmc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extOscClk,
   input wire logic lowPowerOscClk,
   output logic toggleOut,
   output logic irq
);
   import pmc_pkg::*;

   logic [COUNT_W-1:0] count_q;
   logic [COUNT_W-1:0] count_d;
   logic [COUNT_W-1:0] snap_q;
   logic [COUNT_W-1:0] snap_d;
   logic [COUNT_W-1:0] compareBuf_q;
   logic [COUNT_W-1:0] compareBuf_d;
   logic [COUNT_W-1:0] compareAct_q;
   logic [COUNT_W-1:0] compareAct_d;
   logic [DIV_W-1:0] divCnt_q;
   logic [DIV_W-1:0] divCnt_d;
   logic [1:0] src_q;
   logic [1:0] src_d;
   logic [2:0] ps_q;
   logic [2:0] ps_d;
   logic flag_q;
   logic flag_d;
   logic irqEn_q;
   logic irqEn_d;
   logic toggleEn_q;
   logic toggleEn_d;
   logic toggleOut_q;
   logic toggleOut_d;
   logic [EVT_W-1:0] evt_q;
   logic [EVT_W-1:0] evt_d;
   logic [EVT_W-1:0] mask_q;
   logic [EVT_W-1:0] mask_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic mapped_q;
   logic mapped_d;

   logic extRise;
   logic lowPowerRise;
   logic srcTick;
   logic psOn;
   logic [DIV_W-1:0] divisor;
   logic prePulse;
   logic wrapEv;
   logic restart;
   logic setupPh;
   logic wrEn;
   logic hit;
   logic [7:0] readByte;
   logic [1:0] newSrc;
   logic [2:0] newPs;

   // slow source clocks are sampled, never used as clocks
   clock_edge_sync extSync
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .srcLevel(extOscClk),
      .risePulse(extRise)
   );

   clock_edge_sync lowPowerSync
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .srcLevel(lowPowerOscClk),
      .risePulse(lowPowerRise)
   );

   // source selection and divide ratio
   always_comb
   begin
      unique case (clock_source_t'(src_q))
         SRC_EXT_OSC: srcTick = extRise;
         SRC_LOW_POWER: srcTick = lowPowerRise;
         SRC_BUS_A, SRC_BUS_B: srcTick = 1'b1;
      endcase
      if (src_q[0])
         divisor = DIV_DECIMAL[ps_q];
      else
         divisor = DIV_BINARY[ps_q];
   end

   assign psOn = (ps_q != PS_OFF);
   assign prePulse = psOn && srcTick && (divCnt_q == divisor - 12'h001);
   assign wrapEv = prePulse && !restart && (count_q == compareAct_q);

   // bus decode
   assign setupPh = psel && !penable;
   assign wrEn = psel && penable && pwrite;
   assign newSrc = pwdata[SRC_LSB+1:SRC_LSB];
   assign newPs = pwdata[PS_LSB+2:PS_LSB];
   assign restart = wrEn && (paddr == ADDR_CLOCK_CONTROL)
      && ((newSrc != src_q) || (newPs != ps_q));

   always_comb
   begin
      hit = 1'b1;
      readByte = 8'h00;
      unique case (paddr)
         ADDR_STATUS_CONTROL:
         begin
            readByte[FLAG_BIT] = flag_q;
            readByte[IRQ_EN_BIT] = irqEn_q;
            readByte[TOGGLE_EN_BIT] = toggleEn_q;
         end
         ADDR_CLOCK_CONTROL:
         begin
            readByte[SRC_LSB+1:SRC_LSB] = src_q;
            readByte[PS_LSB+2:PS_LSB] = ps_q;
         end
         ADDR_COMPARE_HIGH: readByte = compareBuf_q[15:8];
         ADDR_COMPARE_LOW: readByte = compareBuf_q[7:0];
         ADDR_COUNT_HIGH: readByte = snap_q[15:8];
         ADDR_COUNT_LOW: readByte = count_q[7:0];
         ADDR_EVENT_STATUS: readByte[EVT_W-1:0] = evt_q;
         ADDR_EVENT_MASK: readByte[EVT_W-1:0] = mask_q;
         default: hit = 1'b0;
      endcase
   end

   // next state of the whole block
   always_comb
   begin
      count_d = count_q;
      snap_d = snap_q;
      compareBuf_d = compareBuf_q;
      compareAct_d = compareAct_q;
      divCnt_d = divCnt_q;
      src_d = src_q;
      ps_d = ps_q;
      flag_d = flag_q;
      irqEn_d = irqEn_q;
      toggleEn_d = toggleEn_q;
      toggleOut_d = toggleOut_q;
      evt_d = evt_q;
      mask_d = mask_q;
      rdata_d = rdata_q;
      mapped_d = mapped_q;

      // read data is captured in setup so it comes from a flip-flop
      if (setupPh)
      begin
         rdata_d = {24'h000000, readByte};
         mapped_d = hit;
         // freeze the count together with the low byte being returned
         if (!pwrite && paddr == ADDR_COUNT_LOW)
            snap_d = count_q;
      end

      // read-to-clear: only bits that were returned are cleared
      if (psel && penable && !pwrite && paddr == ADDR_EVENT_STATUS)
         evt_d = evt_q & ~rdata_q[EVT_W-1:0];

      if (wrEn)
      begin
         unique case (paddr)
            ADDR_STATUS_CONTROL:
            begin
               irqEn_d = pwdata[IRQ_EN_BIT];
               toggleEn_d = pwdata[TOGGLE_EN_BIT];
               if (pwdata[FLAG_BIT])
                  flag_d = 1'b0;
            end
            ADDR_CLOCK_CONTROL:
            begin
               src_d = newSrc;
               ps_d = newPs;
               if (newPs != PS_OFF)
                  compareAct_d = compareBuf_q;
            end
            ADDR_COMPARE_HIGH: compareBuf_d[15:8] = pwdata[7:0];
            ADDR_COMPARE_LOW: compareBuf_d[7:0] = pwdata[7:0];
            ADDR_EVENT_MASK: mask_d = pwdata[EVT_W-1:0];
            // count bytes and unmapped offsets drop the write
            default: ;
         endcase
      end

      if (restart)
      begin
         divCnt_d = DIV_RESET;
         count_d = COUNT_RESET;
         evt_d[EVT_RESTART] = 1'b1;
      end
      else if (psOn && srcTick)
      begin
         if (prePulse)
         begin
            divCnt_d = DIV_RESET;
            // compare of zero wraps on every pulse
            if (count_q == compareAct_q)
            begin
               count_d = COUNT_RESET;
               compareAct_d = compareBuf_q;
            end
            else
               count_d = count_q + 16'h0001;
         end
         else
            divCnt_d = divCnt_q + 12'h001;
      end

      // hardware set wins over a same-cycle clear
      if (wrapEv)
      begin
         flag_d = 1'b1;
         evt_d[EVT_WRAP] = 1'b1;
         if (toggleEn_q)
            toggleOut_d = ~toggleOut_q;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         count_q <= COUNT_RESET;
         snap_q <= COUNT_RESET;
         compareBuf_q <= COMPARE_RESET;
         compareAct_q <= COMPARE_RESET;
         divCnt_q <= DIV_RESET;
         src_q <= SRC_RESET;
         ps_q <= PS_OFF;
         flag_q <= 1'b0;
         irqEn_q <= 1'b0;
         toggleEn_q <= 1'b0;
         toggleOut_q <= 1'b0;
         evt_q <= EVT_RESET;
         mask_q <= EVT_RESET;
         rdata_q <= 32'h00000000;
         mapped_q <= 1'b1;
      end
      else
      begin
         count_q <= count_d;
         snap_q <= snap_d;
         compareBuf_q <= compareBuf_d;
         compareAct_q <= compareAct_d;
         divCnt_q <= divCnt_d;
         src_q <= src_d;
         ps_q <= ps_d;
         flag_q <= flag_d;
         irqEn_q <= irqEn_d;
         toggleEn_q <= toggleEn_d;
         toggleOut_q <= toggleOut_d;
         evt_q <= evt_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         mapped_q <= mapped_d;
      end
   end

   // one wait-free access phase; unmapped offsets answer with an error
   assign pready = penable;
   assign pslverr = psel && penable && !mapped_q;
   assign prdata = rdata_q;
   assign toggleOut = toggleOut_q;
   assign irq = (flag_q && irqEn_q) || (|(evt_q & mask_q));

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   a_wrap_to_zero: assert property (
      wrapEv |=> (count_q == 16'h0000) && flag_q)
      else $error("count did not wrap to zero with flag on match");

   a_zero_compare: assert property (
      prePulse && !restart && compareAct_q == 16'h0000 |=> flag_q)
      else $error("zero compare did not flag on a prescaler pulse");

   a_low_freeze: assert property (
      setupPh && !pwrite && paddr == ADDR_COUNT_LOW
      |=> snap_q == $past(count_q))
      else $error("count copy not frozen by low byte read");

   a_count_readonly: assert property (
      wrEn && (paddr == ADDR_COUNT_LOW || paddr == ADDR_COUNT_HIGH)
      && !(psOn && srcTick) |=> $stable(count_q))
      else $error("write to a count byte changed the count");

   a_clear_on_change: assert property (
      restart |=> count_q == 16'h0000 && divCnt_q == 12'h000)
      else $error("source or prescale change did not clear counters");
   a_off_holds: assert property (
      ps_q == PS_OFF ##1 ps_q == PS_OFF |-> $stable(count_q)
      && $stable(divCnt_q))
      else $error("counting while prescaler is off");
   a_bus_source_tick: assert property (
      src_q[1] |-> srcTick)
      else $error("bus clock source gave no tick");
   a_pulse_period: assert property (
      prePulse |-> divCnt_q == divisor - 12'h001 && divisor != 12'h000)
      else $error("prescaler pulse at wrong divide count");
   a_low_power_ratio: assert property (
      src_q == 2'h1 && ps_q == 3'h7 |-> divisor == 12'h3e8)
      else $error("low-power one second ratio wrong");
   a_count_step: assert property (
      prePulse && !restart && count_q != compareAct_q
      |=> count_q == $past(count_q) + 16'h0001)
      else $error("count did not step once per pulse");

   a_flag_cause: assert property (
      $rose(flag_q) |-> $past(wrapEv))
      else $error("flag set without a wrap");

   a_compare_held: assert property (
      !wrapEv && !(wrEn && paddr == ADDR_CLOCK_CONTROL)
      |=> $stable(compareAct_q))
      else $error("active compare changed outside wrap or start");

   a_irq_on_flag: assert property (
      flag_q && irqEn_q |-> irq)
      else $error("interrupt missing with flag and enable");
   a_flag_w1c: assert property (
      flag_q && !(wrEn && paddr == ADDR_STATUS_CONTROL
      && pwdata[FLAG_BIT]) |=> flag_q)
      else $error("flag cleared without a written one");
   a_toggle_wrap: assert property (
      wrapEv && toggleEn_q |=> toggleOut != $past(toggleOut))
      else $error("output pin did not invert at wrap");
   a_toggle_quiet: assert property (
      !wrapEv |=> $stable(toggleOut))
      else $error("output pin moved without a wrap");
   a_irq_disabled: assert property (
      !irqEn_q && (evt_q & mask_q) == 2'h0 |-> !irq)
      else $error("interrupt raised while disabled");

endmodule

//--- rtl/pmc_pkg.sv
// constants for the periodic modulo counter: map, fields, resets, dividers
package pmc_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int COUNT_W = 16;
   localparam int DIV_W = 12;

   // register indices; the byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_STATUS_CONTROL = 16'h306a;
   localparam logic [ADDR_W-1:0] IDX_CLOCK_CONTROL = 16'h306b;
   localparam logic [ADDR_W-1:0] IDX_COMPARE_HIGH = 16'h306c;
   localparam logic [ADDR_W-1:0] IDX_COMPARE_LOW = 16'h306d;
   localparam logic [ADDR_W-1:0] IDX_COUNT_HIGH = 16'h306e;
   localparam logic [ADDR_W-1:0] IDX_COUNT_LOW = 16'h306f;
   localparam logic [ADDR_W-1:0] IDX_EVENT_STATUS = 16'h3070;
   localparam logic [ADDR_W-1:0] IDX_EVENT_MASK = 16'h3071;

   localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = IDX_STATUS_CONTROL << 2;
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL = IDX_CLOCK_CONTROL << 2;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE_HIGH = IDX_COMPARE_HIGH << 2;
   localparam logic [ADDR_W-1:0] ADDR_COMPARE_LOW = IDX_COMPARE_LOW << 2;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = IDX_COUNT_HIGH << 2;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = IDX_COUNT_LOW << 2;
   localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = IDX_EVENT_STATUS << 2;
   localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = IDX_EVENT_MASK << 2;

   // status/control field positions
   localparam int FLAG_BIT = 7;
   localparam int IRQ_EN_BIT = 6;
   localparam int TOGGLE_EN_BIT = 4;
   // clock control field positions
   localparam int SRC_LSB = 6;
   localparam int PS_LSB = 0;

   // event status bits
   localparam int EVT_WRAP = 0;
   localparam int EVT_RESTART = 1;
   localparam int EVT_W = 2;

   typedef enum logic [1:0] {
      SRC_EXT_OSC = 2'h0,
      SRC_LOW_POWER = 2'h1,
      SRC_BUS_A = 2'h2,
      SRC_BUS_B = 2'h3
   } clock_source_t;

   localparam logic [2:0] PS_OFF = 3'h0;
   localparam logic [1:0] SRC_RESET = 2'h0;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [COUNT_W-1:0] COMPARE_RESET = 16'h0000;
   localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
   localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

   // divide ratios per prescale code, binary and decimal families
   localparam logic [DIV_W-1:0] DIV_BINARY [0:7] = '{12'h000, 12'h001,
      12'h002, 12'h004, 12'h008, 12'h010, 12'h020, 12'h040};
   localparam logic [DIV_W-1:0] DIV_DECIMAL [0:7] = '{12'h000, 12'h080,
      12'h100, 12'h200, 12'h400, 12'h800, 12'h064, 12'h3e8};

endpackage
